// file: inc/gsw_defines.svh
// gsw_defines.svh: offsets, field positions, reset values for the guest status word block
// assumes: included by bare name from package and design files
`ifndef GSW_DEFINES_SVH
`define GSW_DEFINES_SVH
`define GSW_OFF_PSW 12'h000
`define GSW_OFF_CFG 12'h004
`define GSW_OFF_IRQ_STAT 12'h008
`define GSW_OFF_IRQ_MASK 12'h00C
`define GSW_OFF_ACK_STAT 12'h010
`define GSW_BIT_UM 30
`define GSW_MASK_HI 25
`define GSW_MASK_LO 20
`define GSW_BIT_CP2 18
`define GSW_BIT_CP1 17
`define GSW_BIT_CP0 16
`define GSW_PRIO_NEVER 6'h3F
`define GSW_PRIO_W 6
`define GSW_CP_RESET 3'h0
`define GSW_MASK_RESET 6'h00
`define GSW_EV_ACK 0
`define GSW_EV_WAKE 1
`define GSW_EV_CPU 2
`define GSW_EV_W 3
`endif

// file: inc/gsw_pkg.sv
// gsw_pkg: types shared by the guest status word block
// assumes: gsw_defines.svh on the include path
`include "gsw_defines.svh"
package gsw_pkg;
    typedef struct packed {
        logic valid;
        logic [5:0] prio;
    } gsw_irq_req_t;
    typedef struct packed {
        logic valid;
        logic [1:0] cop;
    } gsw_cop_req_t;
    typedef enum logic [1:0] {
        GSW_IDLE,
        GSW_ACCESS
    } gsw_apb_state_t;
endpackage

// file: design/gsw_prio_gate.sv
// gsw_prio_gate: decides whether a prioritized maskable request may be acknowledged
// assumes: inputs are on pclk; result is registered for one cycle
`timescale 1ns/100ps
`default_nettype none
`include "gsw_defines.svh"
module gsw_prio_gate
    import gsw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire gsw_irq_req_t req,
    input wire logic [5:0] mask,
    input wire logic level_en,
    input wire logic irq_enable,
    output logic grant_ff,
    output logic wake_ff
);
    logic below_mask;
    logic never_prio;
    logic nxt_grant;
    assign below_mask = !level_en || (req.prio < mask);
    assign never_prio = (req.prio == `GSW_PRIO_NEVER);
    assign nxt_grant = req.valid && irq_enable && below_mask && !never_prio;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            grant_ff <= nxt_grant;
            wake_ff <= req.valid;
        end
    end
endmodule
`default_nettype wire

// file: design/gsw_cop_check.sv
// gsw_cop_check: raises coprocessor-unusable for ops on a coprocessor without permission
// assumes: one op request per cycle from the pipeline on pclk
`timescale 1ns/100ps
`default_nettype none
module gsw_cop_check
    import gsw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire gsw_cop_req_t op,
    input wire logic [2:0] perm,
    output logic fault_ff
);
    logic [3:0] perm_ext;
    logic allowed;
    // code 3 names no coprocessor, so its slot is always empty
    assign perm_ext = {1'b0, perm};
    assign allowed = perm_ext[op.cop];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= op.valid && !allowed;
        end
    end
endmodule
`default_nettype wire

// file: design/gsw_top.sv
// gsw_top: upper fields of the guest program status word with an APB slave
// assumes: interrupt controller holds a request until ack or withdrawal;
// pipeline gives one coprocessor op per cycle; all inputs are on pclk
// limitation: lower status fields live elsewhere and read as zero here
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "gsw_defines.svh"
module gsw_top
    import gsw_pkg::*;
#(
    parameter bit HAS_XFN = 1'b1,
    parameter bit HAS_FPU = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire gsw_irq_req_t irq_req,
    output logic irq_ack,
    output logic [5:0] irq_ack_prio,
    output logic cpu_wake,
    input wire gsw_cop_req_t cop_op,
    output logic cop_unusable,
    output logic guest_user_mode,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic um_ff;
    logic [5:0] mask_ff;
    logic [2:0] cp_ff;
    logic level_en_ff;
    logic irq_en_ff;
    logic [`GSW_EV_W-1:0] stat_ff;
    logic [`GSW_EV_W-1:0] imask_ff;
    logic [5:0] ack_prio_ff;
    logic [31:0] prdata_ff;
    logic irq_ff;
    logic grant;
    logic wake;
    logic fault;
    logic [5:0] req_prio_ff;
    logic pready_ff;
    logic pslverr_ff;
    genvar gi;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic acc;
    logic wr;
    logic hit_psw;
    logic hit_cfg;
    logic hit_stat;
    logic hit_imask;
    logic hit_ack;
    logic mapped;
    wire logic [31:0] wmask;
    logic [31:0] cfg_rd;
    logic [31:0] stat_rd;
    logic [31:0] imask_rd;
    logic [31:0] ack_rd;
    logic cfg_wr;
    logic imask_wr;
    logic stat_wr;
    logic [31:0] wval;
    logic [31:0] psw_rd;
    logic [31:0] rd_mux;
    logic [2:0] cp_present;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign hit_psw = (paddr == `GSW_OFF_PSW);
    assign hit_cfg = (paddr == `GSW_OFF_CFG);
    assign hit_stat = (paddr == `GSW_OFF_IRQ_STAT);
    assign hit_imask = (paddr == `GSW_OFF_IRQ_MASK);
    assign hit_ack = (paddr == `GSW_OFF_ACK_STAT);
    assign mapped = hit_psw || hit_cfg || hit_stat || hit_imask || hit_ack;
    // the other registers only look at lane 0
    assign cfg_wr = wr && hit_cfg && pstrb[0];
    assign imask_wr = wr && hit_imask && pstrb[0];
    assign stat_wr = wr && hit_stat && pstrb[0];
    // byte lanes not strobed keep their old contents
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
        end
    endgenerate
    assign wval = (pwdata & wmask) | (psw_rd & ~wmask);
    // absent coprocessors never hold a permission bit
    assign cp_present = {1'b0, HAS_XFN, HAS_FPU};

    // reserved bits stay zero because nothing stores them
    assign psw_rd = {1'b0, um_ff, 4'h0, mask_ff, 1'b0, cp_ff, 16'h0000};
    assign cfg_rd = {30'h0, irq_en_ff, level_en_ff};
    assign stat_rd = {29'h0, stat_ff};
    assign imask_rd = {29'h0, imask_ff};
    assign ack_rd = {26'h0, ack_prio_ff};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_psw) begin
            rd_mux = psw_rd;
        end else if (hit_cfg) begin
            rd_mux = cfg_rd;
        end else if (hit_stat) begin
            rd_mux = stat_rd;
        end else if (hit_imask) begin
            rd_mux = imask_rd;
        end else if (hit_ack) begin
            rd_mux = ack_rd;
        end
    end

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    logic psw_wr;
    logic [5:0] nxt_mask;
    wire logic [2:0] nxt_cp;
    logic nxt_um;
    assign psw_wr = wr && hit_psw;
    // privilege moves only by software; no hardware event here touches it
    assign nxt_um = psw_wr ? wval[`GSW_BIT_UM] : um_ff;
    // a permission bit exists only where its coprocessor does
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cp
            assign nxt_cp[gi] = cp_present[gi]
                && (psw_wr ? wval[`GSW_BIT_CP0 + gi] : cp_ff[gi]);
        end
    endgenerate
    // acknowledgement update wins over a software write in the same cycle
    always_comb begin
        nxt_mask = mask_ff;
        if (grant && level_en_ff) begin
            nxt_mask = req_prio_ff;
        end else if (psw_wr) begin
            nxt_mask = wval[`GSW_MASK_HI:`GSW_MASK_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            um_ff <= 1'b0;
            mask_ff <= `GSW_MASK_RESET;
            cp_ff <= `GSW_CP_RESET;
        end else begin
            um_ff <= nxt_um;
            mask_ff <= nxt_mask;
            cp_ff <= nxt_cp;
        end
    end

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_en_ff <= 1'b0;
            irq_en_ff <= 1'b0;
        end else if (cfg_wr) begin
            level_en_ff <= pwdata[0];
            irq_en_ff <= pwdata[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_ff <= '0;
        end else if (imask_wr) begin
            imask_ff <= pwdata[`GSW_EV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // acknowledge path
    // ------------------------------------------------------------
    // no new grant while one is out, so one request is never acknowledged twice in a row
    logic gate_en;
    assign gate_en = irq_en_ff && !grant;

    // grant is one cycle behind the request; priority is kept alongside it
    gsw_prio_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .req(irq_req),
        .mask(mask_ff),
        .level_en(level_en_ff),
        .irq_enable(gate_en),
        .grant_ff(grant),
        .wake_ff(wake)
    );

    gsw_cop_check u_cop (
        .pclk(pclk),
        .presetn(presetn),
        .op(cop_op),
        .perm(cp_ff),
        .fault_ff(fault)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prio_ff <= 6'h00;
        end else begin
            req_prio_ff <= irq_req.prio;
        end
    end

    // last acknowledged priority is kept for software; it lags irq_ack by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_prio_ff <= 6'h00;
        end else if (grant) begin
            ack_prio_ff <= req_prio_ff;
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    wire logic [`GSW_EV_W-1:0] ev;
    wire logic [`GSW_EV_W-1:0] clr;
    wire logic [`GSW_EV_W-1:0] nxt_stat;
    assign ev[`GSW_EV_ACK] = grant;
    assign ev[`GSW_EV_WAKE] = wake;
    assign ev[`GSW_EV_CPU] = fault;
    // one sticky bit per event; a new event beats a clear landing in the same cycle
    generate
        for (gi = 0; gi < `GSW_EV_W; gi++) begin : g_ev
            assign clr[gi] = stat_wr && pwdata[gi];
            assign nxt_stat[gi] = (stat_ff[gi] && !clr[gi]) || ev[gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // the line follows the next status so it rises with the status bit, a cycle after the event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_stat & imask_ff);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end

    // the error flag is taken in the setup cycle so the access cycle reads a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= 1'b1;
            pslverr_ff <= psel && !penable && !mapped;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq_ack = grant;
    assign irq_ack_prio = ack_prio_ff;
    assign cpu_wake = wake;
    assign cop_unusable = fault;
    assign guest_user_mode = um_ff;
    assign irq = irq_ff;
endmodule
`default_nettype wire

// file: dv/gsw_top_chk.sv
// gsw_top_chk: port-level assertions for gsw_top
// assumes: bound to gsw_top, one pclk domain
`timescale 1ns/100ps
`default_nettype none
module gsw_top_chk
    import gsw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire gsw_irq_req_t irq_req,
    input wire logic irq_ack,
    input wire logic [5:0] irq_ack_prio,
    input wire logic cpu_wake,
    input wire gsw_cop_req_t cop_op,
    input wire logic cop_unusable,
    input wire logic guest_user_mode
);
    // ----
    // properties
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && paddr == 12'h000;
    property p_rsv; acc && !pwrite |-> (prdata & 32'hBC0C0000) == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_priv; acc && pwrite && pstrb[3] |=> guest_user_mode == $past(pwdata[30]);
    endproperty
    a_priv: assert property (p_priv) else $error("privilege not written");
    property p_no63; irq_ack |-> $past(irq_req.valid) && $past(irq_req.prio) != 6'h3F;
    endproperty
    a_no63: assert property (p_no63) else $error("bad acknowledge");
    property p_wake; irq_req.valid |=> cpu_wake; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_wsrc; $rose(cpu_wake) |-> $past(irq_req.valid); endproperty
    a_wsrc: assert property (p_wsrc) else $error("wake without request");
    property p_aprio; irq_ack |=> irq_ack_prio == $past(irq_req.prio, 2); endproperty
    a_aprio: assert property (p_aprio) else $error("wrong acked priority");
    property p_cbad; cop_op.valid && cop_op.cop[1] |=> cop_unusable; endproperty
    a_cbad: assert property (p_cbad) else $error("no fault on missing unit");
    property p_csrc; $rose(cop_unusable) |-> $past(cop_op.valid); endproperty
    a_csrc: assert property (p_csrc) else $error("fault without op");
    c_ack: cover property (irq_ack);
    c_cop: cover property (cop_unusable);
    c_wr: cover property (acc && pwrite);
endmodule
bind gsw_top gsw_top_chk u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .irq_req(irq_req), .irq_ack(irq_ack), .irq_ack_prio(irq_ack_prio),
    .cpu_wake(cpu_wake), .cop_op(cop_op), .cop_unusable(cop_unusable),
    .guest_user_mode(guest_user_mode));
`default_nettype wire

// file: dv/gsw_irq_src.sv
// gsw_irq_src: interrupt controller model, one prioritized request
// assumes: pclk domain; bench pulses go and drop
`timescale 1ns/100ps
`default_nettype none
module gsw_irq_src
    import gsw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic drop,
    input wire logic [5:0] prio_in,
    input wire logic irq_ack,
    output var gsw_irq_req_t req
);
    // ----
    // request holding
    // ----
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req <= '0;
        end else if (go) begin
            req <= {1'b1, prio_in};
        end else if (irq_ack || drop || !req.valid) begin
            // idle priority toggles so a stale value is never trusted
            req <= {1'b0, ~req.prio};
        end
    end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// testbench: self-checking bench for gsw_top
// assumes: gsw_top and gsw_irq_src compiled before
`timescale 1ns/100ps
`default_nettype none
module testbench
    import gsw_pkg::*;
;
    // ----
    // stimulus and model
    // ----
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic go = 1'b0, drop = 1'b0, pready, pslverr, irq_ack, cpu_wake, cop_unusable;
    logic guest_user_mode, irq, er, ak, wk;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, rs = 32'h180FF;
    logic [5:0] pin = 6'h00, irq_ack_prio;
    gsw_irq_req_t irq_req;
    gsw_cop_req_t cop_op = '0;
    int n_fail = 0, samples_checked = 0, m_psw, i, c, la = 0;
    int lv[8] = '{1, 1, 1, 1, 1, 1, 0, 0};
    int mk[8] = '{0, 10, 10, 63, 63, 1, 0, 0};
    int pr[8] = '{0, 9, 10, 62, 63, 0, 5, 63};
    always #5 pclk = ~pclk;
    gsw_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_ack_prio(irq_ack_prio), .cpu_wake(cpu_wake), .cop_op(cop_op),
        .cop_unusable(cop_unusable), .guest_user_mode(guest_user_mode), .irq(irq));
    gsw_irq_src u_src(.pclk(pclk), .presetn(presetn), .go(go), .drop(drop),
        .prio_in(pin), .irq_ack(irq_ack), .req(irq_req));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task complete_run;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_fail++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task irq_try(input int l, input int m, input int p);
        logic xa;
        xa = p != 63 && (l == 0 || p < m);
        apb(1'b1, 12'h004, 32'(l + 2));
        m_psw = m << 20;
        apb(1'b1, 12'h000, 32'(m_psw));
        @(posedge pclk);
        pin <= 6'(p);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        ak = 1'b0;
        wk = 1'b0;
        repeat (6) begin
            @(posedge pclk);
            #1;
            ak |= irq_ack;
            wk |= cpu_wake;
        end
        @(posedge pclk);
        drop <= 1'b1;
        @(posedge pclk);
        drop <= 1'b0;
        chk(32'(ak), 32'(xa));
        chk(32'(wk), 32'h1);
        if (xa) la = p;
        chk(32'(irq_ack_prio), 32'(la));
        if (xa && l == 1) m_psw = p << 20;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'(m_psw));
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 12'h000, 32'hFFFFFFFF);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h43F30000);
        for (i = 0; i < 6; i++) begin
            rs = lfsr(rs);
            apb(1'b1, 12'h000, rs);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, rs & 32'h43F30000);
            chk(32'(guest_user_mode), 32'(rs[30]));
        end
        $display("test registers done");
        for (i = 0; i < 8; i++) irq_try(lv[i], mk[i], pr[i]);
        // masked events keep the line low until unmasked
        chk(32'(irq), 32'h0);
        apb(1'b1, 12'h00C, 32'h1);
        @(posedge pclk);
        #1;
        chk(32'(irq), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd & 32'h3, 32'h3);
        apb(1'b1, 12'h008, 32'h7);
        @(posedge pclk);
        #1;
        chk(32'(irq), 32'h0);
        $display("test interrupts done");
        for (i = 0; i < 8; i++) begin
            apb(1'b1, 12'h000, 32'(i << 16));
            for (c = 0; c < 4; c++) begin
                @(posedge pclk);
                cop_op <= '{1'b1, 2'(c)};
                @(posedge pclk);
                cop_op <= '0;
                #1;
                chk(32'(cop_unusable), 32'(c > 1 || !i[c]));
            end
        end
        $display("test coprocessor done");
        complete_run();
    end
    initial begin
        #500000;
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
